// *** shared/ims_pkg.sv ***
package ims_pkg;

  // ==========================================================
  // Widths and sizes
  localparam int unsigned PC_W = 13;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned FILE_COUNT = 128;

  // ==========================================================
  // Register map, byte addresses
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] WREG_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] PC_OFS = 12'h00C;
  localparam logic [11:0] LATCH_OFS = 12'h010;
  localparam logic [11:0] STACK_TOP_OFS = 12'h014;
  // File window: 0x200 + 4 * file address
  localparam logic [2:0] FILE_SEL = 3'h1;

  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned STAT_ZERO_BIT = 0;
  localparam int unsigned STAT_POWERDOWN_BIT = 1;
  localparam int unsigned STAT_TIMEOUT_BIT = 2;
  localparam int unsigned LATCH_HI_BIT = 4;
  localparam int unsigned LATCH_LO_BIT = 3;
  localparam int unsigned DEST_BIT = 7;

  // ==========================================================
  // Values after reset
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic TIMEOUT_N_RESET = 1'b1;
  localparam logic POWERDOWN_N_RESET = 1'b1;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic RUN_RESET = 1'b0;

  // ==========================================================
  // Opcode patterns
  localparam logic [5:0] AND_LITERAL_PAT = 6'h39;
  localparam logic [5:0] AND_FILE_PAT = 6'h05;
  localparam logic [5:0] COMPLEMENT_PAT = 6'h09;
  localparam logic [3:0] SKIP_CLEAR_PAT = 4'h6;
  localparam logic [3:0] SKIP_SET_PAT = 4'h7;
  localparam logic [13:0] WATCHDOG_CLEAR_PAT = 14'h0064;
  localparam logic [2:0] CALL_PAT = 3'h4;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_AND_LITERAL = 3'b001,
    OP_AND_FILE = 3'b010,
    OP_COMPLEMENT = 3'b011,
    OP_SKIP_CLEAR = 3'b100,
    OP_SKIP_SET = 3'b101,
    OP_WATCHDOG_CLEAR = 3'b110,
    OP_CALL = 3'b111
  } ims_op_e;

  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_SKIP = 2'b01,
    ST_STALL = 2'b10
  } ims_state_e;

  // Anything outside the subset decodes as a no-op
  function automatic ims_op_e ims_decode(input logic [13:0] instr);
    ims_op_e op;
    op = OP_NONE;
    if (instr[13:8] == AND_LITERAL_PAT)
      op = OP_AND_LITERAL;
    else if (instr[13:8] == AND_FILE_PAT)
      op = OP_AND_FILE;
    else if (instr[13:8] == COMPLEMENT_PAT)
      op = OP_COMPLEMENT;
    else if (instr[13:10] == SKIP_CLEAR_PAT)
      op = OP_SKIP_CLEAR;
    else if (instr[13:10] == SKIP_SET_PAT)
      op = OP_SKIP_SET;
    else if (instr == WATCHDOG_CLEAR_PAT)
      op = OP_WATCHDOG_CLEAR;
    else if (instr[13:11] == CALL_PAT)
      op = OP_CALL;
    return op;
  endfunction

endpackage

// *** hdl/ims_return_stack.sv ***
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Circular return stack; oldest entry is overwritten on overflow
module ims_return_stack #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 13
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Push side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] data_i,
  // Top of stack
  output logic [WIDTH-1:0] top_o
);

  localparam int unsigned PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] ptr;
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } ims_stack_s;

  ims_stack_s q;
  ims_stack_s next_q;

  always_comb
  begin
    next_q = q;
    if (push_i)
    begin
      next_q.mem[q.ptr] = data_i;
      next_q.ptr = PTR_W'(q.ptr + 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      q <= '0;
    else
      q <= next_q;
  end

  assign top_o = q.mem[PTR_W'(q.ptr - 1'b1)];

endmodule
`default_nettype wire

// *** hdl/ims_core.sv ***
// Overview of operation
// - AND literal with W, result into W, zero flag updated.
// - AND W with file register; destination bit picks W or file; zero flag.
// - Complement file register; destination bit picks W or file; zero flag only.
// - Skip-if-clear: bit zero discards next instruction as a no-op cycle.
// - Skip-if-set: bit one discards next instruction as a no-op cycle.
// - Bit-test skips never touch any status flag.
// - Watchdog clear zeroes the watchdog counter.
// - Watchdog clear also clears the watchdog prescaler.
// - Watchdog clear sets timeout and power-down flags (active low) to one.
// - Call pushes program counter plus one onto the return stack.
// - Call loads eleven-bit target into program counter bits 10 to 0.
// - Call fills program counter bits 12:11 from latch bits 4:3.
// - Call takes two cycles and alters no status flag.
// - Program counter change or true test adds a no-op second cycle.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none

module ims_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Program memory, combinational read
  output logic [12:0] prog_addr_o,
  input wire logic [13:0] prog_data_i,
  // Watchdog strobes and flags
  output logic watchdog_clear_o,
  output logic prescaler_clear_o,
  output logic timeout_flag_n_o,
  output logic powerdown_flag_n_o
);

  typedef struct packed {
    ims_pkg::ims_state_e state;
    logic [12:0] pc;
    logic [7:0] w;
    logic [7:0] pc_high_latch;
    logic zero;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic run;
    logic watchdog_clr;
    logic pre_clr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [127:0][7:0] file;
  } ims_core_s;

  ims_core_s q;
  ims_core_s next_q;
  logic stack_push;
  logic [12:0] stack_data;
  logic [12:0] stack_top;
  logic bus_access;
  logic bus_wr;
  logic file_hit;
  logic reg_hit;
  logic exec;
  ims_pkg::ims_op_e op;
  logic [6:0] f_addr;
  logic [2:0] bit_sel;
  logic [7:0] f_val;
  logic dest_file;

  // ==========================================================
  // Return stack
  ims_return_stack #(
    .DEPTH(ims_pkg::STACK_DEPTH),
    .WIDTH(ims_pkg::PC_W)
  ) u_stack (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .push_i(stack_push),
    .data_i(stack_data),
    .top_o(stack_top)
  );

  // ==========================================================
  // Decode
  assign op = ims_pkg::ims_decode(prog_data_i);
  assign f_addr = prog_data_i[6:0];
  assign bit_sel = prog_data_i[9:7];
  assign f_val = q.file[f_addr];
  assign dest_file = prog_data_i[ims_pkg::DEST_BIT];
  assign exec = q.run && (q.state == ims_pkg::ST_EXEC);

  // Write lands only at the edge that sees pready high
  assign bus_access = psel_i && penable_i && !q.pready;
  assign bus_wr = psel_i && penable_i && q.pready && pwrite_i;
  assign file_hit = (paddr_i[11:9] == ims_pkg::FILE_SEL) && (paddr_i[1:0] == 2'h0);
  assign reg_hit = (paddr_i == ims_pkg::CTRL_OFS) || (paddr_i == ims_pkg::WREG_OFS) ||
                   (paddr_i == ims_pkg::STATUS_OFS) || (paddr_i == ims_pkg::PC_OFS) ||
                   (paddr_i == ims_pkg::LATCH_OFS) || (paddr_i == ims_pkg::STACK_TOP_OFS);

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [7:0] res;
    res = 8'h00;
    next_q = q;
    next_q.watchdog_clr = 1'b0;
    next_q.pre_clr = 1'b0;
    next_q.pready = bus_access;
    next_q.pslverr = 1'b0;
    stack_push = 1'b0;
    stack_data = 13'(q.pc + 13'h0001);

    // Bus side; core updates below win on a clash
    if (bus_access)
    begin
      next_q.pslverr = !(reg_hit || file_hit);
      next_q.prdata = 32'h0000_0000;
      if (file_hit)
        next_q.prdata = {24'h00_0000, q.file[paddr_i[8:2]]};
      else
      begin
        case (paddr_i)
          ims_pkg::CTRL_OFS: next_q.prdata = {31'h0000_0000, q.run};
          ims_pkg::WREG_OFS: next_q.prdata = {24'h00_0000, q.w};
          ims_pkg::STATUS_OFS: next_q.prdata = {29'h0000_0000, q.timeout_flag_n,
                                                q.powerdown_flag_n, q.zero};
          ims_pkg::PC_OFS: next_q.prdata = {19'h0_0000, q.pc};
          ims_pkg::LATCH_OFS: next_q.prdata = {24'h00_0000, q.pc_high_latch};
          ims_pkg::STACK_TOP_OFS: next_q.prdata = {19'h0_0000, stack_top};
          default: next_q.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (bus_wr)
    begin
      if (file_hit)
        next_q.file[paddr_i[8:2]] = pwdata_i[7:0];
      else
      begin
        case (paddr_i)
          ims_pkg::CTRL_OFS: next_q.run = pwdata_i[ims_pkg::CTRL_RUN_BIT];
          ims_pkg::WREG_OFS: next_q.w = pwdata_i[7:0];
          ims_pkg::STATUS_OFS:
          begin
            next_q.zero = pwdata_i[ims_pkg::STAT_ZERO_BIT];
            next_q.powerdown_flag_n = pwdata_i[ims_pkg::STAT_POWERDOWN_BIT];
            next_q.timeout_flag_n = pwdata_i[ims_pkg::STAT_TIMEOUT_BIT];
          end
          ims_pkg::PC_OFS:
          begin
            next_q.pc = pwdata_i[12:0];
            next_q.state = ims_pkg::ST_EXEC;
          end
          ims_pkg::LATCH_OFS: next_q.pc_high_latch = pwdata_i[7:0];
          default: next_q.run = q.run;
        endcase
      end
    end

    // Core side
    if (q.run)
    begin
      case (q.state)
        ims_pkg::ST_EXEC:
        begin
          next_q.pc = 13'(q.pc + 13'h0001);
          next_q.state = ims_pkg::ST_EXEC;
          case (op)
            ims_pkg::OP_AND_LITERAL:
            begin
              res = q.w & prog_data_i[7:0];
              next_q.w = res;
              next_q.zero = (res == 8'h00);
            end
            ims_pkg::OP_AND_FILE, ims_pkg::OP_COMPLEMENT:
            begin
              if (op == ims_pkg::OP_AND_FILE)
                res = q.w & f_val;
              else
                res = ~f_val;
              if (dest_file)
                next_q.file[f_addr] = res;
              else
                next_q.w = res;
              next_q.zero = (res == 8'h00);
            end
            ims_pkg::OP_SKIP_CLEAR:
              if (!f_val[bit_sel])
                next_q.state = ims_pkg::ST_SKIP;
            ims_pkg::OP_SKIP_SET:
              if (f_val[bit_sel])
                next_q.state = ims_pkg::ST_SKIP;
            ims_pkg::OP_WATCHDOG_CLEAR:
            begin
              next_q.watchdog_clr = 1'b1;
              next_q.pre_clr = 1'b1;
              next_q.timeout_flag_n = 1'b1;
              next_q.powerdown_flag_n = 1'b1;
            end
            ims_pkg::OP_CALL:
            begin
              stack_push = 1'b1;
              next_q.pc = {q.pc_high_latch[ims_pkg::LATCH_HI_BIT:ims_pkg::LATCH_LO_BIT],
                           prog_data_i[10:0]};
              next_q.state = ims_pkg::ST_STALL;
            end
            default: next_q.state = ims_pkg::ST_EXEC;
          endcase
        end
        // Fetched word is dropped, flags untouched
        ims_pkg::ST_SKIP:
        begin
          next_q.pc = 13'(q.pc + 13'h0001);
          next_q.state = ims_pkg::ST_EXEC;
        end
        // Target already on the bus; hold it one cycle
        ims_pkg::ST_STALL:
          next_q.state = ims_pkg::ST_EXEC;
        default: next_q.state = ims_pkg::ST_EXEC;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      q <= '0;
      q.state <= ims_pkg::ST_EXEC;
      q.pc <= ims_pkg::PC_RESET;
      q.w <= ims_pkg::WREG_RESET;
      q.pc_high_latch <= ims_pkg::LATCH_RESET;
      q.zero <= ims_pkg::ZERO_RESET;
      q.timeout_flag_n <= ims_pkg::TIMEOUT_N_RESET;
      q.powerdown_flag_n <= ims_pkg::POWERDOWN_N_RESET;
      q.run <= ims_pkg::RUN_RESET;
      q.file <= {ims_pkg::FILE_COUNT{ims_pkg::FILE_RESET}};
    end
    else
      q <= next_q;
  end

  // ==========================================================
  // Outputs
  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;
  assign prog_addr_o = q.pc;
  assign watchdog_clear_o = q.watchdog_clr;
  assign prescaler_clear_o = q.pre_clr;
  assign timeout_flag_n_o = q.timeout_flag_n;
  assign powerdown_flag_n_o = q.powerdown_flag_n;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  and_literal_a: assert property (
    exec && op == ims_pkg::OP_AND_LITERAL |=>
      q.w == ($past(q.w) & $past(prog_data_i[7:0])) && q.zero == (q.w == 8'h00))
    else $error("and literal result wrong");

  and_file_a: assert property (
    exec && op == ims_pkg::OP_AND_FILE && !dest_file |=>
      q.w == ($past(q.w) & $past(f_val)) && q.zero == (q.w == 8'h00))
    else $error("and file result wrong");

  complement_dest_a: assert property (
    exec && op == ims_pkg::OP_COMPLEMENT && dest_file && !bus_wr |=>
      q.file[$past(f_addr)] == ~$past(f_val) && $stable(q.w))
    else $error("complement result wrong");

  skip_clear_a: assert property (
    exec && op == ims_pkg::OP_SKIP_CLEAR |=>
      (q.state == ims_pkg::ST_SKIP) == !$past(f_val[bit_sel]))
    else $error("skip if clear decision wrong");

  skip_set_a: assert property (
    exec && op == ims_pkg::OP_SKIP_SET |=>
      (q.state == ims_pkg::ST_SKIP) == $past(f_val[bit_sel]))
    else $error("skip if set decision wrong");

  skip_flags_a: assert property (
    exec && (op == ims_pkg::OP_SKIP_CLEAR || op == ims_pkg::OP_SKIP_SET) && !bus_wr |=>
      $stable(q.zero) && $stable(q.timeout_flag_n) && $stable(q.powerdown_flag_n))
    else $error("bit test changed a flag");

  watchdog_strobe_a: assert property (
    exec && op == ims_pkg::OP_WATCHDOG_CLEAR |=> watchdog_clear_o && prescaler_clear_o)
    else $error("watchdog clear strobes missing");

  // Back-to-back clears may hold the strobes; each strobe cycle needs a cause
  strobe_cause_a: assert property (
    watchdog_clear_o || prescaler_clear_o |->
      $past(exec && op == ims_pkg::OP_WATCHDOG_CLEAR))
    else $error("watchdog clear strobe without cause");

  watchdog_flags_a: assert property (
    exec && op == ims_pkg::OP_WATCHDOG_CLEAR |=> timeout_flag_n_o && powerdown_flag_n_o)
    else $error("watchdog clear flags wrong");

  call_push_a: assert property (
    exec && op == ims_pkg::OP_CALL |=> stack_top == 13'($past(q.pc) + 13'h0001))
    else $error("call return address wrong");

  call_target_a: assert property (
    exec && op == ims_pkg::OP_CALL |=>
      q.pc == {$past(q.pc_high_latch[4:3]), $past(prog_data_i[10:0])})
    else $error("call target wrong");

  call_two_a: assert property (
    exec && op == ims_pkg::OP_CALL && !bus_wr |=>
      q.state == ims_pkg::ST_STALL && $stable(q.zero) ##1
      q.state == ims_pkg::ST_EXEC && $stable(q.pc))
    else $error("call not two cycles");

  nop_cycle_a: assert property (
    q.run && q.state != ims_pkg::ST_EXEC && !bus_wr |=>
      $stable(q.w) && $stable(q.zero) && $stable(q.file))
    else $error("second cycle not a no-op");

endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  typedef struct {
    logic [13:0] i0;
    logic [13:0] i1;
    logic [6:0] fa;
    logic [7:0] w0;
    logic [7:0] f0;
    logic z0;
    logic [7:0] w1;
    logic [7:0] f1;
    logic z1;
  } ims_row_s;

  // ==========================================================
  // Design and program memory
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [12:0] prog_addr_o;
  logic [13:0] prog_data_i;
  logic watchdog_clear_o;
  logic prescaler_clear_o;
  logic timeout_flag_n_o;
  logic powerdown_flag_n_o;
  logic [13:0] pmem [0:8191];
  int n_errors = 0;
  int n_checks = 0;

  always #5 clk_i = ~clk_i;
  assign prog_data_i = pmem[prog_addr_o];

  ims_core DUT (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .prog_addr_o(prog_addr_o),
    .prog_data_i(prog_data_i),
    .watchdog_clear_o(watchdog_clear_o),
    .prescaler_clear_o(prescaler_clear_o),
    .timeout_flag_n_o(timeout_flag_n_o),
    .powerdown_flag_n_o(powerdown_flag_n_o)
  );

  // ==========================================================
  // Ordinary cases: second word shows whether a skip happened
  ims_row_s rows [11] = '{
    '{{6'h39, 8'h3C}, 14'h0000, 7'h10, 8'hF0, 8'h55, 1'b1, 8'h30, 8'h55, 1'b0},
    '{{6'h39, 8'hF0}, 14'h0000, 7'h10, 8'h0F, 8'h55, 1'b0, 8'h00, 8'h55, 1'b1},
    '{{6'h05, 1'b0, 7'h7F}, 14'h0000, 7'h7F, 8'hCC, 8'hAA, 1'b1, 8'h88, 8'hAA, 1'b0},
    '{{6'h05, 1'b1, 7'h7F}, 14'h0000, 7'h7F, 8'h33, 8'hCC, 1'b0, 8'h33, 8'h00, 1'b1},
    '{{6'h09, 1'b0, 7'h00}, 14'h0000, 7'h00, 8'h12, 8'h5A, 1'b1, 8'hA5, 8'h5A, 1'b0},
    '{{6'h09, 1'b1, 7'h00}, 14'h0000, 7'h00, 8'h12, 8'hFF, 1'b0, 8'h12, 8'h00, 1'b1},
    '{{4'h6, 3'd7, 7'h7F}, 14'h3900, 7'h7F, 8'hFF, 8'h7F, 1'b0, 8'hFF, 8'h7F, 1'b0},
    '{{4'h6, 3'd0, 7'h7F}, 14'h3900, 7'h7F, 8'hFF, 8'h01, 1'b0, 8'h00, 8'h01, 1'b1},
    '{{4'h7, 3'd7, 7'h7F}, 14'h3900, 7'h7F, 8'hFF, 8'h80, 1'b0, 8'hFF, 8'h80, 1'b0},
    '{{4'h7, 3'd0, 7'h7F}, 14'h3900, 7'h7F, 8'hFF, 8'hFE, 1'b0, 8'h00, 8'hFE, 1'b1},
    '{{4'h6, 3'd3, 7'h10}, 14'h3900, 7'h10, 8'hFF, 8'h00, 1'b1, 8'hFF, 8'h00, 1'b1}
  };

  // ==========================================================
  // Checking and bus tasks
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= is_wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t bus answer missing", $time);
      tally_and_finish;
    end
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp, what);
  endtask

  function automatic logic [11:0] fad(input logic [6:0] f);
    return {ims_pkg::FILE_SEL, f, 2'b00};
  endfunction

  // Runs a few cycles only: everything past the program is no-op words
  task automatic run_prog(input logic [12:0] pc);
    wr(ims_pkg::PC_OFS, {19'h0, pc});
    wr(ims_pkg::CTRL_OFS, 32'h1);
    repeat (6) @(posedge clk_i);
    wr(ims_pkg::CTRL_OFS, 32'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] r;
    logic e;
    logic [12:0] prev;
    int k;
    for (k = 0; k < 8192; k++)
      pmem[k] = 14'h0000;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    chk({timeout_flag_n_o, powerdown_flag_n_o, watchdog_clear_o}, 32'h6, "reset flags");
    chk({19'h0, prog_addr_o}, 32'h0, "reset pc");
    rd(ims_pkg::STATUS_OFS, 32'h6, "reset status");
    rd(ims_pkg::WREG_OFS, 32'h0, "reset w");
    rd(ims_pkg::STACK_TOP_OFS, 32'h0, "reset stack");
    $display("reset test done");

    foreach (rows[i])
    begin
      pmem[0] = rows[i].i0;
      pmem[1] = rows[i].i1;
      wr(ims_pkg::WREG_OFS, {24'h0, rows[i].w0});
      wr(fad(rows[i].fa), {24'h0, rows[i].f0});
      wr(ims_pkg::STATUS_OFS, {29'h0, 2'b11, rows[i].z0});
      run_prog(13'h0000);
      rd(ims_pkg::WREG_OFS, {24'h0, rows[i].w1}, "w");
      rd(fad(rows[i].fa), {24'h0, rows[i].f1}, "file");
      rd(ims_pkg::STATUS_OFS, {29'h0, 2'b11, rows[i].z1}, "status");
      $display("row %0d done", i);
    end

    // Watchdog clear: both strobes in one cycle, flags back to one
    pmem[0] = 14'h0064;
    pmem[1] = 14'h0000;
    wr(ims_pkg::STATUS_OFS, 32'h0);
    // Write lands at the edge the task returns on; look one edge later
    @(posedge clk_i);
    chk({timeout_flag_n_o, powerdown_flag_n_o}, 32'h0, "flags low");
    wr(ims_pkg::PC_OFS, 32'h0);
    wr(ims_pkg::CTRL_OFS, 32'h1);
    for (k = 0; k < 20 && watchdog_clear_o !== 1'b1; k++)
      @(posedge clk_i);
    chk({31'h0, watchdog_clear_o}, 32'h1, "watchdog strobe");
    chk({31'h0, prescaler_clear_o}, 32'h1, "prescaler strobe");
    @(posedge clk_i);
    chk({watchdog_clear_o, prescaler_clear_o}, 32'h0, "strobe length");
    chk({timeout_flag_n_o, powerdown_flag_n_o}, 32'h3, "flags set");
    wr(ims_pkg::CTRL_OFS, 32'h0);
    rd(ims_pkg::STATUS_OFS, 32'h6, "status after clear");
    $display("watchdog test done");

    // Call with unused latch bits set; word after call must not run
    pmem[0] = 14'h0000;
    pmem[5] = {3'h4, 11'h7FF};
    pmem[6] = 14'h3900;
    wr(ims_pkg::LATCH_OFS, 32'hF7);
    wr(ims_pkg::WREG_OFS, 32'hFF);
    wr(ims_pkg::STATUS_OFS, 32'h7);
    wr(ims_pkg::PC_OFS, 32'h5);
    wr(ims_pkg::CTRL_OFS, 32'h1);
    prev = 13'h0000;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_i);
      if (prog_addr_o === 13'h17FF)
        break;
      prev = prog_addr_o;
    end
    chk({19'h0, prev}, 32'h5, "pc before target");
    @(posedge clk_i);
    chk({19'h0, prog_addr_o}, 32'h17FF, "call stall");
    @(posedge clk_i);
    chk({19'h0, prog_addr_o}, 32'h1800, "target runs");
    wr(ims_pkg::CTRL_OFS, 32'h0);
    rd(ims_pkg::STACK_TOP_OFS, 32'h6, "return address");
    rd(ims_pkg::WREG_OFS, 32'hFF, "w after call");
    rd(ims_pkg::STATUS_OFS, 32'h7, "status after call");
    $display("call test done");

    // Refused accesses
    wr(ims_pkg::STACK_TOP_OFS, 32'h1234);
    rd(ims_pkg::STACK_TOP_OFS, 32'h6, "stack read only");
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk({e, r[30:0]}, 32'h8000_0000, "unmapped read");
    rd(ims_pkg::LATCH_OFS, 32'hF7, "latch readback");
    $display("bus test done");

    // Reset in mid-run: run, W, latch, status, stack top and PC back to their reset values
    wr(ims_pkg::STATUS_OFS, 32'h1);
    wr(ims_pkg::CTRL_OFS, 32'h1);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({29'h0, timeout_flag_n_o, powerdown_flag_n_o, watchdog_clear_o}, 32'h6, "flags in reset");
    chk({19'h0, prog_addr_o}, 32'h0, "pc in reset");
    reset_n_i <= 1'b1;
    rd(ims_pkg::CTRL_OFS, 32'h0, "run after reset");
    rd(ims_pkg::WREG_OFS, 32'h0, "w after reset");
    rd(ims_pkg::LATCH_OFS, 32'h0, "latch after reset");
    rd(ims_pkg::STATUS_OFS, 32'h6, "status after reset");
    rd(ims_pkg::STACK_TOP_OFS, 32'h0, "stack after reset");
    $display("mid-run reset test done");
    tally_and_finish;
  end

  initial
  begin
    #500000;
    n_errors++;
    $display("BAD %0t run too long", $time);
    tally_and_finish;
  end
endmodule

`default_nettype wire
